/* testbench.sv */
// Self-checking testbench for the queue control register block
`timescale 1ns/100ps
module testbench;
    import ufc_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    ufc_host_t host = '0;
    logic [4:0] rx_count = 5'h00;
    logic rx_push = 1'b0;
    logic rx_pop = 1'b0;
    logic tick = 1'b0;
    logic [3:0] rdy = 4'h0;
    ufc_cfg_t cfg;
    logic txf, rxf, qmi, lvl, tmo, rro, tro;
    logic [1:0] imb;
    int errors = 0;
    int checks_done = 0;
    int cyc = 0;
    // Rows: written byte, then {indicator, ident bits, tx flush, rx flush, cfg}
    logic [16:0] rows [5] = '{{8'h01, 9'h1c1}, {8'h47, 9'h1f5}, {8'h8d, 9'h1eb},
        {8'hf1, 9'h1cd}, {8'hc8, 9'h03c}};
    logic [4:0] thr [4] = '{UFC_THR_1, UFC_THR_4, UFC_THR_8, UFC_THR_14};
    always #5 clk = ~clk;
    ufc_queue_control ufc_queue_control_inst (.clk(clk), .sys_rst(sys_rst), .host(host),
        .rx_count(rx_count), .rx_push(rx_push), .rx_pop(rx_pop), .char_time_tick(tick),
        .cfg(cfg), .tx_queue_flush(txf), .rx_queue_flush(rxf), .queue_mode_indicator(qmi),
        .ident_mode_bits(imb), .rx_level_irq(lvl), .rx_timeout_irq(tmo),
        .receive_ready_out(rro), .transmit_ready_out(tro), .rx_ready_mode0(rdy[0]),
        .rx_ready_mode1(rdy[1]), .tx_ready_mode0(rdy[2]), .tx_ready_mode1(rdy[3]));
    task automatic final_report();
        $display("errors=%0d checks_done=%0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Strobe is raised for exactly one sampling edge, then dropped
    task automatic wr(input logic rd, input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        host <= '{~rd, rd, a, d};
        @(posedge clk);
        host <= '0;
        #1;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        chk({qmi, imb, txf, rxf, cfg, lvl, tmo}, 12'h000);
        sys_rst <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            wr(1'b0, 3'h2, rows[i][16:9]);
            chk({qmi, imb, txf, rxf, cfg}, rows[i][8:0]);
            @(posedge clk);
            #1 chk({txf, rxf}, 12'h000);
        end
        wr(1'b0, 3'h2, 8'h01);
        wr(1'b1, 3'h2, 8'h00);
        wr(1'b0, 3'h3, 8'hc0);
        chk(cfg, 12'h001);
        for (int c = 0; c < 4; c++) begin
            wr(1'b0, 3'h2, {c[1:0], 6'h01});
            @(posedge clk) rx_count <= thr[c] - 5'h01;
            #1 chk(lvl, 12'h000);
            @(posedge clk) rx_count <= thr[c];
            #1 chk(lvl, 12'h001);
        end
        @(posedge clk) rdy <= 4'h5;
        #1 chk({rro, tro}, 12'h003);
        wr(1'b0, 3'h2, 8'h09);
        chk({rro, tro}, 12'h000);
        @(posedge clk) rx_count <= 5'h02;
        repeat (3) begin
            @(posedge clk) tick <= 1'b1;
            @(posedge clk) tick <= 1'b0;
        end
        repeat (2) @(posedge clk);
        #1 chk(tmo, 12'h000);
        @(posedge clk) tick <= 1'b1;
        @(posedge clk) tick <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk(tmo, 12'h001);
        @(posedge clk) rx_pop <= 1'b1;
        @(posedge clk) rx_pop <= 1'b0;
        #1 chk(tmo, 12'h000);
        // A push among the ticks restarts the idle count
        for (int k = 0; k < 5; k++) begin
            @(posedge clk) tick <= (k != 3);
            rx_push <= (k == 3);
            @(posedge clk) tick <= 1'b0;
            rx_push <= 1'b0;
        end
        repeat (2) @(posedge clk);
        #1 chk(tmo, 12'h000);
        wr(1'b0, 3'h2, 8'h00);
        @(posedge clk) rx_count <= 5'h0e;
        #1 chk({lvl, qmi, imb}, 12'h000);
        wr(1'b0, 3'h2, 8'hcf);
        @(posedge clk) sys_rst <= 1'b1;
        @(posedge clk) sys_rst <= 1'b0;
        #1 chk({qmi, imb, txf, rxf, cfg, tmo}, 12'h000);
        final_report();
    end
    // Hang guard; the sequence needs well under a few hundred cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc > 2000) begin
            errors++;
            final_report();
        end
    end
endmodule // testbench

/* ufc_pkg.sv */
// Package for the serial channel queue control block
package ufc_pkg;
    localparam logic [2:0] UFC_QCTRL_OFS = 3'h2;
    localparam int UFC_ENABLE_BIT = 0;
    localparam int UFC_RXFLUSH_BIT = 1;
    localparam int UFC_TXFLUSH_BIT = 2;
    localparam int UFC_DMASEL_BIT = 3;
    localparam int UFC_THR_LO_BIT = 6;
    localparam int UFC_THR_HI_BIT = 7;
    localparam logic [4:0] UFC_THR_1 = 5'h01;
    localparam logic [4:0] UFC_THR_4 = 5'h04;
    localparam logic [4:0] UFC_THR_8 = 5'h08;
    localparam logic [4:0] UFC_THR_14 = 5'h0e;
    localparam int UFC_TIMEOUT_CHARS = 4;
    localparam logic [7:0] UFC_QCTRL_RST = 8'h00;

    typedef struct packed {
        logic [1:0] thr;
        logic dma_signal_select;
        logic enable;
    } ufc_cfg_t;

    typedef struct packed {
        logic host_wr;
        logic host_rd;
        logic [2:0] addr;
        logic [7:0] wdata;
    } ufc_host_t;
endpackage

/* ufc_queue_control.sv */
// Queue control register of the serial channel and its effects on the queues
`timescale 1ns/100ps
// Contract
// - Offset two write-only queue control register
// - Bits 7:6 pick threshold 1/4/8/14
// - Bit 3 selects DMA signalling mode 1
// - Bit 2 empties transmit queue only
// - Transmit flush bit clears itself
// - Bit 1 empties receive queue, self-clears
// - Bit 0 enables queues; zero empties both
// - Identification reads show enable bits 7:6
// - Receive interrupt tracks threshold level
// - Timeout after four idle character times
module ufc_queue_control
    import ufc_pkg::*;
#(
    parameter int DEPTH_W = 5
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire ufc_host_t host,
    input wire logic [DEPTH_W-1:0] rx_count,
    input wire logic rx_push,
    input wire logic rx_pop,
    input wire logic char_time_tick,
    output ufc_cfg_t cfg,
    output logic tx_queue_flush,
    output logic rx_queue_flush,
    output logic queue_mode_indicator,
    output logic [1:0] ident_mode_bits,
    output logic rx_level_irq,
    output logic rx_timeout_irq,
    output logic receive_ready_out,
    output logic transmit_ready_out,
    input wire logic rx_ready_mode0,
    input wire logic rx_ready_mode1,
    input wire logic tx_ready_mode0,
    input wire logic tx_ready_mode1
);
    ufc_cfg_t cfg_q;
    logic tx_flush_q;
    logic rx_flush_q;
    logic [2:0] idle_q;
    logic timeout_q;
    logic qwr;
    logic [4:0] thr_bytes;

    assign qwr = host.host_wr && host.addr == UFC_QCTRL_OFS;

    // Bits 5:4 are never stored
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_q <= '0;
        end else if (qwr) begin
            cfg_q.enable <= host.wdata[UFC_ENABLE_BIT];
            // Other settings only land when enable is written as one
            if (host.wdata[UFC_ENABLE_BIT]) begin
                cfg_q.thr <= host.wdata[UFC_THR_HI_BIT:UFC_THR_LO_BIT];
                cfg_q.dma_signal_select <= host.wdata[UFC_DMASEL_BIT];
            end
        end
    end

    // Flush pulses last one cycle and self-clear; disabling empties both
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_flush_q <= 1'b0;
            rx_flush_q <= 1'b0;
        end else begin
            tx_flush_q <= qwr && (!host.wdata[UFC_ENABLE_BIT] ||
                                  host.wdata[UFC_TXFLUSH_BIT]);
            rx_flush_q <= qwr && (!host.wdata[UFC_ENABLE_BIT] ||
                                  host.wdata[UFC_RXFLUSH_BIT]);
        end
    end

    assign tx_queue_flush = tx_flush_q;
    assign rx_queue_flush = rx_flush_q;
    assign cfg = cfg_q;
    assign queue_mode_indicator = cfg_q.enable;
    // Register itself is never read back, only mode bits on the shared offset
    assign ident_mode_bits = {2{cfg_q.enable}};

    always_comb begin
        case (cfg_q.thr)
            2'b00: thr_bytes = UFC_THR_1;
            2'b01: thr_bytes = UFC_THR_4;
            2'b10: thr_bytes = UFC_THR_8;
            default: thr_bytes = UFC_THR_14;
        endcase
    end

    assign rx_level_irq = cfg_q.enable &&
        ({{(8-DEPTH_W){1'b0}}, rx_count} >= {3'h0, thr_bytes});

    // Idle counter restarts on any queue traffic; timeout cleared by a read
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            idle_q <= 3'h0;
            timeout_q <= 1'b0;
        end else if (!cfg_q.enable || rx_push || rx_pop || rx_count == '0 || rx_flush_q) begin
            idle_q <= 3'h0;
            timeout_q <= 1'b0;
        end else if (char_time_tick && !timeout_q) begin
            if (idle_q == 3'(UFC_TIMEOUT_CHARS - 1)) begin
                timeout_q <= 1'b1;
            end
            idle_q <= idle_q + 3'h1;
        end
    end

    assign rx_timeout_irq = timeout_q;

    // Board leaves these unconnected, mode still honoured
    assign receive_ready_out = cfg_q.dma_signal_select ? rx_ready_mode1 : rx_ready_mode0;
    assign transmit_ready_out = cfg_q.dma_signal_select ? tx_ready_mode1 : tx_ready_mode0;

    property p_tx_flush_pulse;
        @(posedge clk) disable iff (sys_rst)
        tx_flush_q |=> !tx_flush_q || $past(qwr);
    endproperty
    a_tx_flush_pulse: assert property (p_tx_flush_pulse) else $error("tx flush stuck");

    property p_disable_flush;
        @(posedge clk) disable iff (sys_rst)
        (qwr && !host.wdata[UFC_ENABLE_BIT]) |=> (tx_flush_q && rx_flush_q && !cfg_q.enable);
    endproperty
    a_disable_flush: assert property (p_disable_flush) else $error("disable did not empty");

    property p_rx_flush;
        @(posedge clk) disable iff (sys_rst)
        (qwr && host.wdata[UFC_RXFLUSH_BIT]) |=> rx_flush_q;
    endproperty
    a_rx_flush: assert property (p_rx_flush) else $error("rx flush missing");

    property p_thr_load;
        @(posedge clk) disable iff (sys_rst)
        (qwr && host.wdata[UFC_ENABLE_BIT]) |=>
            cfg_q.thr == $past(host.wdata[UFC_THR_HI_BIT:UFC_THR_LO_BIT]);
    endproperty
    a_thr_load: assert property (p_thr_load) else $error("threshold not loaded");

    property p_ident;
        @(posedge clk) disable iff (sys_rst)
        qwr |=> ident_mode_bits == {2{$past(host.wdata[UFC_ENABLE_BIT])}};
    endproperty
    a_ident: assert property (p_ident) else $error("mode bits wrong");

    property p_level;
        @(posedge clk) disable iff (sys_rst)
        (cfg_q.enable && cfg_q.thr == 2'b11 && rx_count >= DEPTH_W'(UFC_THR_14)) |-> rx_level_irq;
    endproperty
    a_level: assert property (p_level) else $error("level irq missing");

    property p_timeout_clear;
        @(posedge clk) disable iff (sys_rst)
        (timeout_q && rx_pop) |=> !timeout_q;
    endproperty
    a_timeout_clear: assert property (p_timeout_clear) else $error("timeout not cleared");

    property p_dma_sel;
        @(posedge clk) disable iff (sys_rst)
        (qwr && host.wdata == 8'h09) |=> (cfg_q.dma_signal_select &&
            receive_ready_out == rx_ready_mode1);
    endproperty
    a_dma_sel: assert property (p_dma_sel) else $error("dma mode not applied");

    property p_no_enable_keep;
        @(posedge clk) disable iff (sys_rst)
        (qwr && !host.wdata[UFC_ENABLE_BIT]) |=> $stable(cfg_q.thr);
    endproperty
    a_no_enable_keep: assert property (p_no_enable_keep) else $error("setting without enable");

    // Flush bits are strobes, so a lone write must give exactly one pulse
    sequence s_lone_tx_flush_write;
        (qwr && host.wdata[UFC_TXFLUSH_BIT]) ##1 !qwr;
    endsequence

    sequence s_tx_pulse_then_clear;
        tx_flush_q ##1 !tx_flush_q;
    endsequence

    property p_tx_self_clear;
        @(posedge clk) disable iff (sys_rst)
        s_lone_tx_flush_write |-> s_tx_pulse_then_clear;
    endproperty
    a_tx_self_clear: assert property (p_tx_self_clear) else $error("tx pulse wrong");

    sequence s_lone_rx_flush_write;
        (qwr && host.wdata[UFC_RXFLUSH_BIT]) ##1 !qwr;
    endsequence

    sequence s_rx_pulse_then_clear;
        rx_flush_q ##1 !rx_flush_q;
    endsequence

    property p_rx_self_clear;
        @(posedge clk) disable iff (sys_rst)
        s_lone_rx_flush_write |-> s_rx_pulse_then_clear;
    endproperty
    a_rx_self_clear: assert property (p_rx_self_clear) else $error("rx pulse wrong");

    property p_tx_flush_only;
        @(posedge clk) disable iff (sys_rst)
        (qwr && host.wdata[UFC_ENABLE_BIT] && host.wdata[UFC_TXFLUSH_BIT] &&
            !host.wdata[UFC_RXFLUSH_BIT]) |=> (tx_flush_q && !rx_flush_q);
    endproperty
    a_tx_flush_only: assert property (p_tx_flush_only) else $error("tx flush hit rx");

    // Reads land on the identification register, never on this one
    property p_read_no_effect;
        @(posedge clk) disable iff (sys_rst)
        (host.host_rd && !host.host_wr) |=>
            ($stable(cfg_q) && !tx_flush_q && !rx_flush_q);
    endproperty
    a_read_no_effect: assert property (p_read_no_effect) else $error("read had effect");

    property p_foreign_offset;
        @(posedge clk) disable iff (sys_rst)
        (host.host_wr && host.addr != UFC_QCTRL_OFS) |=>
            ($stable(cfg_q) && !tx_flush_q && !rx_flush_q);
    endproperty
    a_foreign_offset: assert property (p_foreign_offset) else $error("wrong offset");

    property p_level_low;
        @(posedge clk) disable iff (sys_rst)
        (cfg_q.thr == 2'b10 && rx_count < DEPTH_W'(UFC_THR_8)) |-> !rx_level_irq;
    endproperty
    a_level_low: assert property (p_level_low) else $error("level irq too early");

    property p_timeout_quiet;
        @(posedge clk) disable iff (sys_rst)
        (!cfg_q.enable || rx_push || rx_count == '0) |=> !timeout_q;
    endproperty
    a_timeout_quiet: assert property (p_timeout_quiet) else $error("timeout while busy");

    property p_dma_off;
        @(posedge clk) disable iff (sys_rst)
        (qwr && host.wdata[UFC_ENABLE_BIT] && !host.wdata[UFC_DMASEL_BIT]) |=>
            (!cfg_q.dma_signal_select && transmit_ready_out == tx_ready_mode0);
    endproperty
    a_dma_off: assert property (p_dma_off) else $error("dma mode 0 missing");
endmodule // ufc_queue_control
